// ==== i2c_status_flags_tb.sv ====
// i2c_status_flags_tb: self-checking bench for the status-flag block.
// assumes a single ahb-lite master with hready tied to the slave's hreadyout.
`timescale 1ns/1ps
module i2c_status_flags_tb;
  import i2csf_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = HTRANS_IDLE;
  logic [2:0]  hsize = 3'h2;
  logic        arb_lost_pulse = 1'h0;
  logic        addr_valid_pulse = 1'h0;
  logic [7:0]  calling_addr_byte = 8'h00;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, scl_in, sda_in, irq;
  logic        bus_busy, arbitration_lost_flag, range_address_match, slave_read_write_flag;
  logic [7:0]  first_control_register, d;
  logic [6:0]  p, u, a;
  logic        en, dir, m;
  int          fail_count = 0;
  int          check_count = 0;
  int          seed = 97098;

  always #25 clk = ~clk;

  i2csf_top i2csf_top_i (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .sda_in(sda_in),
    .arb_lost_pulse(arb_lost_pulse), .addr_valid_pulse(addr_valid_pulse),
    .calling_addr_byte(calling_addr_byte), .bus_busy(bus_busy),
    .arbitration_lost_flag(arbitration_lost_flag), .range_address_match(range_address_match),
    .slave_read_write_flag(slave_read_write_flag),
    .first_control_register(first_control_register), .irq(irq)
  );
  i2csf_bus_model i2csf_bus_model_i (.clk(clk), .scl(scl_in), .sda(sda_in));

  // ==========================================================================
  // shared tasks
  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; address phase, then data phase, each until hready
  task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, adr};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    check(32'(hresp), 32'(HRESP_OKAY));
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    ahb(1'h0, adr, 32'h0);
    check(rd, exp);
  endtask
  // one-cycle engine pulses; flags are looked at on the following low phase
  task automatic engine(input logic arb, input logic av, input logic [7:0] b);
    @(posedge clk);
    arb_lost_pulse <= arb;
    addr_valid_pulse <= av;
    calling_addr_byte <= b;
    @(posedge clk);
    arb_lost_pulse <= 1'h0;
    addr_valid_pulse <= 1'h0;
    @(negedge clk);
  endtask
  // inclusive range; equality with the upper bound never matches address zero
  function automatic logic exp_match(input logic [6:0] ca, lo, hi, input logic ren);
    return (ca != 7'h00 && ca == hi) || (ren && ca >= lo && ca <= hi);
  endfunction

  // ==========================================================================
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i <= 8; i++) rchk(8'(i * 4), RST_WORD);
    ahb(1'h1, OFF_IRQ_ENABLE, 32'hf);
    i2csf_bus_model_i.send_start();
    check(32'({bus_busy, irq}), 32'h3);
    ahb(1'h1, OFF_BUS_STATUS, 32'hffff_ffef);
    rchk(OFF_BUS_STATUS, 32'h20);
    rchk(OFF_IRQ_STATUS, 32'h1);
    ahb(1'h1, OFF_IRQ_ENABLE, 32'h0);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0);
    ahb(1'h1, OFF_IRQ_CLEAR, 32'hf);
    ahb(1'h1, OFF_IRQ_ENABLE, 32'hf);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0);
    // arbitration loss: write of zero keeps it, write of one clears it
    engine(1'h1, 1'h0, 8'h00);
    check(32'(arbitration_lost_flag), 32'h1);
    ahb(1'h1, OFF_BUS_STATUS, 32'hffff_ffef);
    rchk(OFF_BUS_STATUS, 32'h30);
    ahb(1'h1, OFF_BUS_STATUS, 32'h10);
    rchk(OFF_BUS_STATUS, 32'h20);
    // address matching: corner cases first, then random bounds and addresses
    for (int n = 0; n < 24; n++) begin
      p = 7'($random(seed));
      u = 7'($random(seed));
      a = 7'($random(seed));
      en = 1'($random(seed));
      dir = 1'($random(seed));
      d = 8'($random(seed));
      case (n)
        0: a = u;
        1: begin a = 7'h00; u = 7'h00; end
        2: begin u = 7'h50; p = 7'h4d; a = p; en = 1'h1; end
        3: begin u = 7'h50; p = 7'h10; a = 7'h51; en = 1'h1; end
        default: ;
      endcase
      ahb(1'h1, OFF_PRIMARY_ADDR, {24'h0, p, 1'h0});
      ahb(1'h1, OFF_UPPER_ADDR, {24'h0, u, 1'h0});
      ahb(1'h1, OFF_RANGE_CTRL, {31'h0, en});
      ahb(1'h1, OFF_FIRST_CTRL, {24'h0, d});
      @(negedge clk);
      check(32'({range_address_match, first_control_register}), {24'h0, d});
      engine(1'h0, 1'h1, {a, dir});
      m = exp_match(a, p, u, en);
      check(32'({range_address_match, slave_read_write_flag}), 32'({m, m & dir}));
      ahb(1'h1, OFF_BUS_STATUS, 32'hffff_ffff);
      rchk(OFF_BUS_STATUS, {26'h0, 2'h2, m, m & dir, 2'h0});
    end
    i2csf_bus_model_i.send_stop();
    check(32'(bus_busy), 32'h0);
    // stop, arbitration loss and the forced match of case 2 are all pending
    rchk(OFF_IRQ_STATUS, 32'he);
    check(32'(irq), 32'h1);
    ahb(1'h1, OFF_IRQ_CLEAR, 32'hf);
    rchk(OFF_IRQ_STATUS, 32'h0);
    check(32'(irq), 32'h0);
    end_of_test();
  end
endmodule

// ==== i2csf_bus_model.sv ====
// i2csf_bus_model: another master on the two-wire bus making start and stop.
// assumes pulled-up lines, so both rest high when nobody pulls them low.
`timescale 1ns/1ps
module i2csf_bus_model (
  input wire logic clk,
  output logic     scl,
  output logic     sda
);
  // idle lines sit at the pull-up level
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data falls with clock high; levels held long enough for the pin filter
  task automatic send_start();
    hold(1);
    scl <= 1'h1;
    hold(6);
    sda <= 1'h0;
    hold(8);
    scl <= 1'h0;
    hold(4);
  endtask
  // data rises with clock high
  task automatic send_stop();
    hold(1);
    sda <= 1'h0;
    hold(4);
    scl <= 1'h1;
    hold(6);
    sda <= 1'h1;
    hold(8);
  endtask
endmodule

// ==== i2csf_monitor.sv ====
// i2csf_monitor: concurrent checks on the status-flag block ports.
// assumes it is bound to i2csf_top and sees only that module's ports.
`timescale 1ns/1ps
module i2csf_monitor
  import i2csf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        arb_lost_pulse,
  input wire logic        addr_valid_pulse,
  input wire logic [7:0]  calling_addr_byte,
  input wire logic        bus_busy,
  input wire logic        arbitration_lost_flag,
  input wire logic        range_address_match,
  input wire logic        slave_read_write_flag
);
  // ==========================================================================
  // data phase tracker: write side effects land at the end of the data phase
  logic       wr_ph;
  logic [7:0] wr_off;
  always_ff @(posedge clk) begin
    wr_ph  <= !rst && hsel && hready && htrans[1] && hwrite;
    wr_off <= haddr[7:0];
  end
  wire arb_lost_wr = wr_ph && wr_off == OFF_BUS_STATUS && hwdata[BIT_ARB_LOST];
  wire ctrl_wr = wr_ph && wr_off == OFF_FIRST_CTRL;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // flag checks
  a_arb_lost_sets: assert property (arb_lost_pulse |=> arbitration_lost_flag)
    else $error("arbitration flag not set");
  a_arb_lost_sticky: assert property (
    arbitration_lost_flag && !arb_lost_wr |=> arbitration_lost_flag)
    else $error("arbitration flag dropped");
  a_arb_lost_clear: assert property (
    arb_lost_wr && !arb_lost_pulse |=> !arbitration_lost_flag)
    else $error("arbitration flag not cleared");
  a_ctrl_clears: assert property (ctrl_wr && !addr_valid_pulse |=> !range_address_match)
    else $error("control write left match set");
  a_match_hold: assert property (range_address_match && !ctrl_wr |=> range_address_match)
    else $error("match flag dropped");
  a_dir_follows_call: assert property (
    addr_valid_pulse ##1 $rose(range_address_match)
    |-> slave_read_write_flag == $past(calling_addr_byte[0])) else $error("direction wrong");
  a_dir_idle_zero: assert property (!range_address_match |-> !slave_read_write_flag)
    else $error("direction set while unaddressed");
  a_busy_start: assert property (scl_in && $past(scl_in, 4) && $fell(sda_in)
    ##1 (scl_in && !sda_in)[*6] |-> bus_busy) else $error("start missed");
  a_busy_stop: assert property (scl_in && $past(scl_in, 4) && $rose(sda_in)
    ##1 (scl_in && sda_in)[*6] |-> !bus_busy) else $error("stop missed");
  a_busy_steady: assert property ($stable(sda_in)[*8] |-> $stable(bus_busy))
    else $error("busy moved without bus condition");
endmodule

bind i2csf_top i2csf_monitor i2csf_monitor_i (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .scl_in(scl_in), .sda_in(sda_in),
  .arb_lost_pulse(arb_lost_pulse), .addr_valid_pulse(addr_valid_pulse),
  .calling_addr_byte(calling_addr_byte), .bus_busy(bus_busy),
  .arbitration_lost_flag(arbitration_lost_flag), .range_address_match(range_address_match),
  .slave_read_write_flag(slave_read_write_flag)
);

// ==== i2csf_pkg.sv ====
// i2csf_pkg: register map, field positions, reset values and event layout
// for the two-wire bus status-flag block.
// assumes a 32-bit AHB-Lite register port with one aligned word per register.

package i2csf_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_BUS_STATUS   = 8'h00;
  localparam logic [7:0] OFF_FIRST_CTRL   = 8'h04;
  localparam logic [7:0] OFF_PRIMARY_ADDR = 8'h08;
  localparam logic [7:0] OFF_UPPER_ADDR   = 8'h0c;
  localparam logic [7:0] OFF_RANGE_CTRL   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h1c;

  // ==========================================================================
  // bus_status field positions
  localparam int BIT_BUSY        = 5;
  localparam int BIT_ARB_LOST    = 4;
  localparam int BIT_RANGE_MATCH = 3;
  localparam int BIT_SLAVE_DIR   = 2;

  // range control field position
  localparam int BIT_RANGE_EN = 0;

  // slave address registers hold the 7-bit address in bits 7:1
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;

  // ==========================================================================
  // event bits shared by irq status, clear and enable registers
  localparam int EV_START    = 0;
  localparam int EV_STOP     = 1;
  localparam int EV_ARB_LOST = 2;
  localparam int EV_MATCH    = 3;
  localparam int EV_NUM      = 4;

  // ==========================================================================
  // reset values
  localparam logic [7:0]        RST_BYTE   = 8'h00;
  localparam logic [EV_NUM-1:0] RST_EVENTS = 4'h0;
  localparam logic [31:0]       RST_WORD   = 32'h0000_0000;

  // ==========================================================================
  // ahb-lite codes
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ==== i2csf_top.sv ====
// i2csf_top: bus-busy, arbitration-lost, range-address-match and slave
// read/write flags of a two-wire bus controller, with an ahb-lite register
// port and one level interrupt.
// assumes scl/sda pin levels arrive asynchronously; arbitration loss and the
// received calling address come from the transfer engine on the same clock.
// addr_valid_pulse marks each received calling address for one cycle only.

`timescale 1ns/1ps

module i2csf_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // two-wire bus pin levels
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  // transfer engine, same clock
  input  wire logic                        arb_lost_pulse,
  input  wire logic                        addr_valid_pulse,
  input  wire logic [7:0]                  calling_addr_byte,
  // flag outputs
  output logic                             bus_busy,
  output logic                             arbitration_lost_flag,
  output logic                             range_address_match,
  output logic                             slave_read_write_flag,
  output logic [7:0]                       first_control_register,
  output logic                             irq
);
  import i2csf_pkg::*;

  // ==========================================================================
  // helpers

  // word offset decode, used for both read and write selection
  // only the low address byte is decoded, so the map repeats every 256 bytes
  function automatic logic offset_is(input logic [7:0] a, input logic [7:0] off);
    offset_is = (a == off);
  endfunction

  // ==========================================================================
  // pin synchronisers
  // three stages per pin; the filtered level only moves when stages two and
  // three agree, which also rejects a single-cycle glitch on the wire.
  // the stages reset to the pull-up level, so leaving reset never shows a
  // false falling edge on either line; the price is about four clocks of
  // latency on each line
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_level;
  logic       sda_level;
  logic       scl_level_d;
  logic       sda_level_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // filtered levels and their one-cycle delayed copies for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_level   <= 1'h1;
      sda_level   <= 1'h1;
      scl_level_d <= 1'h1;
      sda_level_d <= 1'h1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_level <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_level <= sda_sync[2];
      end
      scl_level_d <= scl_level;
      sda_level_d <= sda_level;
    end
  end

  // ==========================================================================
  // start / stop detection
  // sda falling with scl high and steady is a START (repeated START too);
  // sda rising with scl high and steady is a STOP
  // limitation: each line level must stand for at least two clocks, or the
  // filter swallows it and the condition is missed; a faster bus needs a
  // faster block clock
  wire scl_high_steady = scl_level & scl_level_d;
  wire start_seen      = scl_high_steady & sda_level_d & ~sda_level;
  wire stop_seen       = scl_high_steady & ~sda_level_d & sda_level;

  // ==========================================================================
  // ahb-lite address phase capture
  logic       wr_pending;
  logic [7:0] wr_offset;

  wire bus_take   = hsel & hready & htrans[1];
  wire take_write = bus_take & hwrite;
  wire take_read  = bus_take & ~hwrite;
  wire [7:0] rd_offset = haddr[7:0];

  // data-phase write strobes, decoded from the captured offset
  wire wr_status   = wr_pending & offset_is(wr_offset, OFF_BUS_STATUS);
  wire wr_ctrl1    = wr_pending & offset_is(wr_offset, OFF_FIRST_CTRL);
  wire wr_primary  = wr_pending & offset_is(wr_offset, OFF_PRIMARY_ADDR);
  wire wr_upper    = wr_pending & offset_is(wr_offset, OFF_UPPER_ADDR);
  wire wr_range    = wr_pending & offset_is(wr_offset, OFF_RANGE_CTRL);
  wire wr_irq_clr  = wr_pending & offset_is(wr_offset, OFF_IRQ_CLEAR);
  wire wr_irq_en   = wr_pending & offset_is(wr_offset, OFF_IRQ_ENABLE);

  // the slave never stalls, so a write is applied at the end of its data phase
  // hazard: a read whose address phase falls in that same data phase still
  // returns the value from before the write, since read data is taken early.
  // the offset is latched every cycle; it only matters while a write is
  // pending, which saves an enable on eight flops
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pending <= 1'h0;
      wr_offset  <= RST_BYTE;
    end else begin
      wr_pending <= take_write;
      wr_offset  <= haddr[7:0];
    end
  end

  // ==========================================================================
  // software registers
  logic [7:0]        primary_slave_address;
  logic [7:0]        upper_bound_slave_address;
  logic              range_match_enable;
  logic [EV_NUM-1:0] irq_enable;

  // hsize is not decoded: every access is taken as a whole word and only the
  // low byte of each register carries meaning
  // plain storage; a write to the first control register also clears the match flag
  always_ff @(posedge clk) begin
    if (rst) begin
      first_control_register    <= RST_BYTE;
      primary_slave_address     <= RST_BYTE;
      upper_bound_slave_address <= RST_BYTE;
      range_match_enable        <= 1'h0;
      irq_enable                <= RST_EVENTS;
    end else begin
      if (wr_ctrl1) begin
        first_control_register <= hwdata[7:0];
      end
      if (wr_primary) begin
        primary_slave_address <= hwdata[7:0];
      end
      if (wr_upper) begin
        upper_bound_slave_address <= hwdata[7:0];
      end
      if (wr_range) begin
        range_match_enable <= hwdata[BIT_RANGE_EN];
      end
      if (wr_irq_en) begin
        irq_enable <= hwdata[EV_NUM-1:0];
      end
    end
  end

  // ==========================================================================
  // calling address comparison
  // addresses compare on the 7-bit field; the range is inclusive at both ends
  // a zero address never matches by equality with the upper bound, but an
  // enabled range whose low bound is zero does accept it
  // address and bounds are plain unsigned compares on seven bits
  wire [6:0] call_addr  = calling_addr_byte[ADDR_MSB:ADDR_LSB];
  wire       call_dir   = calling_addr_byte[0];
  wire [6:0] low_bound  = primary_slave_address[ADDR_MSB:ADDR_LSB];
  wire [6:0] high_bound = upper_bound_slave_address[ADDR_MSB:ADDR_LSB];

  wire upper_hit = (call_addr != 7'h00) && (call_addr == high_bound);
  wire range_hit = range_match_enable &&
                   (call_addr >= low_bound) && (call_addr <= high_bound);
  wire match_set = addr_valid_pulse & (upper_hit | range_hit);

  // ==========================================================================
  // status flags
  // every flag below is a flop that drives its output pin directly
  logic dir_captured;

  // only a one in the arbitration-lost position of a bus_status write clears
  // anything; every other bit of that register ignores software
  wire arb_lost_clear = wr_status & hwdata[BIT_ARB_LOST];

  // busy follows the line: START sets, STOP clears, in master or slave role
  // a repeated START while busy simply keeps the flag set
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_busy <= 1'h0;
    end else if (start_seen) begin
      bus_busy <= 1'h1;
    end else if (stop_seen) begin
      bus_busy <= 1'h0;
    end
  end

  // arbitration lost: sticky, write-one-to-clear; a loss in the clearing
  // cycle wins so that no event is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      arbitration_lost_flag <= 1'h0;
    end else begin
      arbitration_lost_flag <= arb_lost_pulse |
                               (arbitration_lost_flag & ~arb_lost_clear);
    end
  end

  // range match: set by a matching calling address, cleared by any write to
  // the first control register; a match in that cycle wins. status writes
  // never touch it.
  always_ff @(posedge clk) begin
    if (rst) begin
      range_address_match <= 1'h0;
    end else begin
      range_address_match <= match_set | (range_address_match & ~wr_ctrl1);
    end
  end

  // direction bit is latched with each matching address: 0 master writes,
  // 1 master reads
  // the flag is held, not recomputed, so a later nonmatching address seen
  // while still addressed leaves it alone
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_captured <= 1'h0;
    end else if (match_set) begin
      dir_captured <= call_dir;
    end
  end

  // the direction flag only means something while addressed; it reads zero
  // otherwise, and bus_status writes leave it alone
  wire next_slave_dir = (match_set ? call_dir : dir_captured) &
                        (match_set | (range_address_match & ~wr_ctrl1));

  always_ff @(posedge clk) begin
    if (rst) begin
      slave_read_write_flag <= 1'h0;
    end else begin
      slave_read_write_flag <= next_slave_dir;
    end
  end

  // ==========================================================================
  // interrupt status: one sticky bit per event, write-one-to-clear
  // the enable register only masks the output; status bits always record,
  // so software can poll with the interrupt disabled
  logic [EV_NUM-1:0] irq_status;
  wire  [EV_NUM-1:0] event_pulse;

  assign event_pulse[EV_START]    = start_seen;
  assign event_pulse[EV_STOP]     = stop_seen;
  assign event_pulse[EV_ARB_LOST] = arb_lost_pulse;
  assign event_pulse[EV_MATCH]    = match_set;

  genvar gi;
  generate
    for (gi = 0; gi < EV_NUM; gi = gi + 1) begin : g_irq
      // set wins over a clear in the same cycle, so an event that lands
      // during the clearing write is never lost
      always_ff @(posedge clk) begin
        if (rst) begin
          irq_status[gi] <= 1'h0;
        end else begin
          irq_status[gi] <= event_pulse[gi] | (irq_status[gi] & ~(wr_irq_clr & hwdata[gi]));
        end
      end
    end
  endgenerate

  // level interrupt, registered so the pin is a flop output; it lags the
  // status bits by one cycle
  // software that clears a status bit may still see irq high for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================================
  // read mux
  // bus_status is assembled from the live flags; unmapped offsets and the
  // write-only clear register read zero, as it has no storage to show
  logic [7:0] status_byte;

  always_comb begin
    status_byte                  = RST_BYTE;
    status_byte[BIT_BUSY]        = bus_busy;
    status_byte[BIT_ARB_LOST]    = arbitration_lost_flag;
    status_byte[BIT_RANGE_MATCH] = range_address_match;
    status_byte[BIT_SLAVE_DIR]   = slave_read_write_flag;
  end

  wire [31:0] rd_word =
      offset_is(rd_offset, OFF_BUS_STATUS)   ? {24'h00_0000, status_byte} :
      offset_is(rd_offset, OFF_FIRST_CTRL)   ? {24'h00_0000, first_control_register} :
      offset_is(rd_offset, OFF_PRIMARY_ADDR) ? {24'h00_0000, primary_slave_address} :
      offset_is(rd_offset, OFF_UPPER_ADDR)   ? {24'h00_0000, upper_bound_slave_address} :
      offset_is(rd_offset, OFF_RANGE_CTRL)   ? {31'h0000_0000, range_match_enable} :
      offset_is(rd_offset, OFF_IRQ_STATUS)   ? {28'h000_0000, irq_status} :
      offset_is(rd_offset, OFF_IRQ_ENABLE)   ? {28'h000_0000, irq_enable} :
      RST_WORD;

  // read data is sampled at the address phase and held through the data
  // phase; a flag that changes during the data phase shows next read
  // hrdata holds between reads, so a master that samples late still sees it
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= RST_WORD;
    end else if (take_read) begin
      hrdata <= rd_word;
    end
  end

  // zero wait states, always OKAY; both are registered so that every output
  // of the block leaves a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'h1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule
